// [verilog/flc_device.sv]
// device end: paged limit registers, fault checks, alert
// What this block does
// - current over warning sets flags, alert
// - warning above fault limit rejected, flagged
// - device keeps warning at most fault limit
// - warning word: exponent -1, seven writable bits
// - warning mantissa resets to 54
// - host programs warning 2 A to 49 A
// - temperature over fault limit sets flags, alert
// - output off until 20 below, then restart
// - fault limit not above warning rejected
// - fault word: exponent 0, eight writable bits
// - fault limit resets to 145
// - host programs fault 120 to 165
// - one copy of limits per page
// - store command copies limits to memory
// - comms flag marks rejected data
// - temperature warning register, checked on writes
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "flc_map.svh"
module flc_device
    import flc_pkg::*;
#(
    parameter int NCH = 2
)(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    flc_link_if.devEnd             link,
    input  wire logic              measStrobe,
    input  wire logic [NCH*11-1:0] currentMeas,
    input  wire logic [NCH*8-1:0]  tempMeas,
    output wire logic [NCH-1:0]    outputOn,
    output wire logic [NCH-1:0]    softStart,
    output logic                   nvmWe,
    output logic      [7:0]        nvmAddr,
    output logic      [15:0]       nvmWdata
);
    localparam int PW = $clog2(NCH);

    logic [2:0]    pinS;
    logic          clkPrev;
    logic          framePrev;
    logic [4:0]    bitCnt;
    logic [24:0]   rxShift;
    logic [15:0]   rspShift;
    logic          loadReq;
    logic [PW-1:0] page;
    logic          ivdF;
    logic          badCmdF;
    logic          rspLine;
    logic          alertN;
    logic          storeRun;
    logic [PW+1:0] sIdx;
    logic [15:0]   rdWord;
    logic [7:0]    sByte;
    logic [15:0]   sWord;
    flc_frame_t    rx;
    // per page storage
    logic [6:0]    ocWarn [NCH];
    logic [6:0]    ocFlt  [NCH];
    logic [7:0]    otFlt  [NCH];
    logic [7:0]    otWarn [NCH];
    logic          ocwF   [NCH];
    logic          otfF   [NCH];
    logic          otwF   [NCH];
    logic          onReg  [NCH];
    logic          ssReg  [NCH];
    logic [NCH-1:0] anyF;

    // link pins in; frame enters inverted so reset reads idle
    flc_sync #(.W(3)) uSync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .d      ({link.linkClk, ~link.frameN, link.cmdLine}),
        .q      (pinS)
    );

    // link edges and frame end
    wire logic sClk     = pinS[2];
    wire logic sFrameN  = ~pinS[1];
    wire logic sData    = pinS[0];
    wire logic rise     = sClk & ~clkPrev & ~sFrameN;
    wire logic fall     = ~sClk & clkPrev & ~sFrameN;
    wire logic frameEnd = sFrameN & ~framePrev;
    assign rx = flc_frame_t'(rxShift);
    wire logic [7:0] rdCmd = rxShift[7:0];
    wire logic wrDone = frameEnd & ~rx.rd
                      & (bitCnt == `FLC_FRAME_BITS);
    // selected page copies
    wire logic [6:0] ocWarnS = ocWarn[page];
    wire logic [6:0] ocFltS  = ocFlt[page];
    wire logic [7:0] otFltS  = otFlt[page];
    wire logic [7:0] otWarnS = otWarn[page];

    // write command decode
    wire logic isPage  = rx.cmd == `FLC_CMD_PAGE;
    wire logic isClr   = rx.cmd == `FLC_CMD_CLEAR;
    wire logic isStore = rx.cmd == `FLC_CMD_STORE;
    wire logic isOcW   = rx.cmd == `FLC_CMD_OCWARN;
    wire logic isOcF   = rx.cmd == `FLC_CMD_OCFLT;
    wire logic isOtF   = rx.cmd == `FLC_CMD_OTFLT;
    wire logic isOtW   = rx.cmd == `FLC_CMD_OTWARN;
    wire logic known   = isPage | isClr | isStore | isOcW
                       | isOcF | isOtF | isOtW;
    wire logic okOcW = rx.data[6:0] <= ocFltS;
    wire logic okOcF = rx.data[6:0] >= ocWarnS;
    wire logic okOtF = rx.data[7:0] > otWarnS;
    wire logic okOtW = rx.data[7:0] < otFltS;
    wire logic rejEv = wrDone & ((isOcW & ~okOcW) | (isOcF & ~okOcF)
                     | (isOtF & ~okOtF) | (isOtW & ~okOtW));
    wire logic badEv = wrDone & ~known;
    wire logic wOcW  = wrDone & isOcW & okOcW;
    wire logic wOcF  = wrDone & isOcF & okOcF;
    wire logic wOtF  = wrDone & isOtF & okOtF;
    wire logic wOtW  = wrDone & isOtW & okOtW;
    wire logic clrEv = wrDone & isClr;
    wire logic [PW-1:0] sCh = sIdx[PW+1:2];
    wire logic lastIdx = sIdx == (PW+2)'(NCH * 4 - 1);

    // link shift in, bit count
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clkPrev   <= 1'b0;
            framePrev <= 1'b1;
            bitCnt    <= 5'h00;
            rxShift   <= '0;
            loadReq   <= 1'b0;
        end
        else
        begin
            clkPrev   <= sClk;
            framePrev <= sFrameN;
            loadReq   <= rise & (bitCnt == `FLC_HDR_BITS - 5'h01);
            if (sFrameN)
                bitCnt <= 5'h00;
            else if (rise && bitCnt != `FLC_FRAME_BITS)
                bitCnt <= bitCnt + 5'h01;
            if (rise)
                rxShift <= {rxShift[23:0], sData};
        end
    end

    // read word shifted out on falling edges
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rspShift <= 16'h0000;
            rspLine  <= 1'b0;
        end
        else if (loadReq)
            rspShift <= rdWord;
        else if (fall && bitCnt >= `FLC_HDR_BITS)
        begin
            rspLine  <= rspShift[15];
            rspShift <= {rspShift[14:0], 1'b0};
        end
    end

    // page select and comms flags
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            page    <= '0;
            ivdF    <= 1'b0;
            badCmdF <= 1'b0;
        end
        else
        begin
            if (wrDone && isPage)
                page <= rx.data[PW-1:0];
            ivdF    <= (ivdF & ~clrEv) | rejEv;
            badCmdF <= (badCmdF & ~clrEv) | badEv;
        end
    end

    // status bytes of the selected page
    always_comb
    begin
        sByte = 8'h00;
        sByte[`FLC_SB_OFF]   = ~onReg[page];
        sByte[`FLC_SB_TEMP]  = otfF[page] | otwF[page];
        sByte[`FLC_SB_CML]   = ivdF | badCmdF;
        sByte[`FLC_SB_OTHER] = ocwF[page];
        sWord = {8'h00, sByte};
        sWord[`FLC_SW_IOUT]  = ocwF[page];
    end

    always_comb
    begin
        rdWord = 16'h0000;
        case (rdCmd)
            `FLC_CMD_PAGE:   rdWord = 16'(page);
            `FLC_CMD_OCWARN: rdWord = {`FLC_OC_EXP, 4'h0, ocWarnS};
            `FLC_CMD_OCFLT:  rdWord = {`FLC_OC_EXP, 4'h0, ocFltS};
            `FLC_CMD_OTFLT:  rdWord = {`FLC_OT_EXP, 3'h0, otFltS};
            `FLC_CMD_OTWARN: rdWord = {`FLC_OT_EXP, 3'h0, otWarnS};
            `FLC_CMD_SBYTE:  rdWord = {8'h00, sByte};
            `FLC_CMD_SWORD:  rdWord = sWord;
            `FLC_CMD_SIOUT:  rdWord = 16'(ocwF[page]) << `FLC_SI_OCW;
            `FLC_CMD_STEMP:  rdWord = (16'(otfF[page]) << `FLC_ST_OTF)
                                    | (16'(otwF[page]) << `FLC_ST_OTW);
            `FLC_CMD_SCML:   rdWord = (16'(badCmdF) << `FLC_SC_BADCMD)
                                    | (16'(ivdF) << `FLC_SC_IVD);
            default:         rdWord = 16'h0000;
        endcase
    end

    // store walk, one word a cycle
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            storeRun <= 1'b0;
            sIdx     <= '0;
            nvmWe    <= 1'b0;
            nvmAddr  <= 8'h00;
            nvmWdata <= 16'h0000;
        end
        else
        begin
            nvmWe <= storeRun;
            if (storeRun)
            begin
                nvmAddr <= 8'(sIdx);
                case (sIdx[1:0])
                    2'h0:    nvmWdata <= {`FLC_OC_EXP, 4'h0, ocWarn[sCh]};
                    2'h1:    nvmWdata <= {`FLC_OC_EXP, 4'h0, ocFlt[sCh]};
                    2'h2:    nvmWdata <= {`FLC_OT_EXP, 3'h0, otFlt[sCh]};
                    default: nvmWdata <= {`FLC_OT_EXP, 3'h0, otWarn[sCh]};
                endcase
                sIdx <= sIdx + 1'b1;
                if (lastIdx)
                    storeRun <= 1'b0;
            end
            else if (wrDone && isStore)
            begin
                storeRun <= 1'b1;
                sIdx     <= '0;
            end
        end
    end

    for (genvar g = 0; g < NCH; g++)
    begin : gCh
        wire logic [10:0] cur = currentMeas[g*11 +: 11];
        wire logic [7:0]  tmp = tempMeas[g*8 +: 8];
        wire logic sel = page == PW'(g);
        wire logic setOcw = measStrobe & (cur > {4'h0, ocWarn[g]});
        wire logic setOtf = measStrobe & (tmp > otFlt[g]);
        wire logic setOtw = measStrobe & (tmp > otWarn[g]);
        wire logic cool   = measStrobe
                          & ({1'b0, tmp} + `FLC_OT_HYST <= {1'b0, otFlt[g]});

        always_ff @(posedge mclk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                ocWarn[g] <= 7'(`FLC_OCWARN_RST);
                ocFlt[g]  <= 7'(`FLC_OCFLT_RST);
                otFlt[g]  <= 8'(`FLC_OTFLT_RST);
                otWarn[g] <= 8'(`FLC_OTWARN_RST);
            end
            else if (sel)
            begin
                if (wOcW) ocWarn[g] <= rx.data[6:0];
                if (wOcF) ocFlt[g]  <= rx.data[6:0];
                if (wOtF) otFlt[g]  <= rx.data[7:0];
                if (wOtW) otWarn[g] <= rx.data[7:0];
            end
        end

        always_ff @(posedge mclk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                ocwF[g] <= 1'b0;
                otfF[g] <= 1'b0;
                otwF[g] <= 1'b0;
            end
            else
            begin
                ocwF[g] <= (ocwF[g] & ~clrEv) | setOcw;
                otfF[g] <= (otfF[g] & ~clrEv) | setOtf;
                otwF[g] <= (otwF[g] & ~clrEv) | setOtw;
            end
        end

        always_ff @(posedge mclk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                onReg[g] <= 1'b1;
                ssReg[g] <= 1'b0;
            end
            else
            begin
                ssReg[g] <= ~onReg[g] & ~setOtf & cool;
                if (setOtf)
                    onReg[g] <= 1'b0;
                else if (cool)
                    onReg[g] <= 1'b1;
            end
        end

        assign outputOn[g]  = onReg[g];
        assign softStart[g] = ssReg[g];
        assign anyF[g]      = ocwF[g] | otfF[g] | otwF[g];
    end

    // alert low while any flag stands
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            alertN <= 1'b1;
        else
            alertN <= ~(|anyF | ivdF | badCmdF);
    end

    assign link.rspLine = rspLine;
    assign link.alertN  = alertN;
endmodule // flc_device

// [verilog/flc_map.svh]
// offsets, field positions, reset values and timing of the checker
`ifndef FLC_MAP_SVH
`define FLC_MAP_SVH
// command codes seen on the link
`define FLC_CMD_PAGE    8'h00
`define FLC_CMD_CLEAR   8'h03
`define FLC_CMD_STORE   8'h15
`define FLC_CMD_OCFLT   8'h46
`define FLC_CMD_OCWARN  8'h4a
`define FLC_CMD_OTFLT   8'h4f
`define FLC_CMD_OTWARN  8'h51
`define FLC_CMD_SBYTE   8'h78
`define FLC_CMD_SWORD   8'h79
`define FLC_CMD_SIOUT   8'h7b
`define FLC_CMD_STEMP   8'h7d
`define FLC_CMD_SCML    8'h7e
// reset values of the limit words
`define FLC_OCWARN_RST  16'hf836
`define FLC_OCFLT_RST   16'hf83c
`define FLC_OTFLT_RST   16'h0091
`define FLC_OTWARN_RST  16'h007d
// fixed exponent fields
`define FLC_OC_EXP      5'h1f
`define FLC_OT_EXP      5'h00
// status bit positions
`define FLC_SB_OFF      6
`define FLC_SB_TEMP     2
`define FLC_SB_CML      1
`define FLC_SB_OTHER    0
`define FLC_SW_IOUT     14
`define FLC_SI_OCW      5
`define FLC_ST_OTF      7
`define FLC_ST_OTW      6
`define FLC_SC_BADCMD   7
`define FLC_SC_IVD      6
// restart hysteresis in degrees
`define FLC_OT_HYST     9'h014
// link frame: read flag, command, data word
`define FLC_FRAME_BITS  5'h19
`define FLC_HDR_BITS    5'h09
// link clock timing
`define FLC_LINK_PERIOD_NS 160
`define FLC_MCLK_NS        8
`define FLC_LINK_HALF (`FLC_LINK_PERIOD_NS / `FLC_MCLK_NS / 2)
// host register offsets
`define FLC_A_CMD       8'h00
`define FLC_A_STAT      8'h04
`define FLC_A_RDATA     8'h08
`define FLC_A_IRQS      8'h0c
`define FLC_A_IRQM      8'h10
`define FLC_IRQ_DONE    0
`define FLC_IRQ_ALERT   1
`endif

// [verilog/flc_pkg.sv]
// frame type shared by both ends of the limit checker link, state type of the host end
package flc_pkg;
    typedef enum logic [2:0] {
        FLC_H_IDLE = 3'b001,
        FLC_H_RUN  = 3'b010,
        FLC_H_END  = 3'b100
    } flc_hstate_t;
    typedef struct packed {
        logic        rd;
        logic [7:0]  cmd;
        logic [15:0] data;
    } flc_frame_t;
endpackage

// [verilog/flc_link_if.sv]
// serial link between host end and device end
`timescale 1ns/1ps
interface flc_link_if;
    logic linkClk;   // made by the host
    logic frameN;    // low during a frame
    logic cmdLine;   // host to device bits
    logic rspLine;   // device to host bits
    logic alertN;    // alert, active low
    modport hostEnd (
        output linkClk,
        output frameN,
        output cmdLine,
        input  rspLine,
        input  alertN
    );
    modport devEnd (
        input  linkClk,
        input  frameN,
        input  cmdLine,
        output rspLine,
        output alertN
    );
endinterface // flc_link_if

// [verilog/flc_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module flc_sync #(
    parameter int W = 1
)(
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage read by second only
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // flc_sync

// [verilog/flc_host.sv]
// host end: AXI4-Lite command registers driving the link
`timescale 1ns/1ps
`include "flc_map.svh"
module flc_host
    import flc_pkg::*;
#(
    parameter int LINK_HALF = `FLC_LINK_HALF
)(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    flc_link_if.hostEnd      link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);
    flc_hstate_t state;
    logic [1:0]  inS;
    logic [7:0]  divCnt;
    logic [24:0] txShift;
    logic [15:0] rdShift;
    logic [4:0]  bitCnt;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [1:0]  irqStat;
    logic [1:0]  irqMask;
    logic        alertPrev;
    logic        linkClk;
    logic        frameN;
    logic        cmdLine;
    logic [31:0] rdMux;

    // rsp and alert in; alert inverted so reset is quiet
    flc_sync #(.W(2)) uSync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .d      ({link.rspLine, ~link.alertN}),
        .q      (inS)
    );

    // decode of the pending write
    wire logic wrGo  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire logic idle  = state == FLC_H_IDLE;
    wire logic aCmd  = awAddr == `FLC_A_CMD;
    wire logic aIrqS = awAddr == `FLC_A_IRQS;
    wire logic aIrqM = awAddr == `FLC_A_IRQM;
    wire logic wrMap = aCmd | aIrqS | aIrqM;
    wire logic launch = wrGo & aCmd & idle;
    wire logic tick  = divCnt == 8'(LINK_HALF - 1);
    wire logic alertNow = inS[0];
    wire logic doneEv = (state == FLC_H_END) & tick;
    wire logic [1:0] setEv = {alertNow & ~alertPrev, doneEv};
    wire logic [1:0] w1c = (wrGo & aIrqS) ? wData[1:0] : 2'h0;
    wire logic rdMap = s_axi_araddr <= `FLC_A_IRQM
                     && s_axi_araddr[1:0] == 2'h0;
    wire flc_frame_t txWord = flc_frame_t'(wData[24:0]);

    // register read selection
    always_comb
    begin
        rdMux = 32'h0000_0000;
        case (s_axi_araddr)
            `FLC_A_STAT:  rdMux = {30'h0, ~idle, alertNow};
            `FLC_A_RDATA: rdMux = {16'h0000, rdShift};
            `FLC_A_IRQS:  rdMux = {30'h0, irqStat};
            `FLC_A_IRQM:  rdMux = {30'h0, irqMask};
            default:      rdMux = 32'h0000_0000;
        endcase
    end

    // write channels: addr and data in any order
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            awAddr        <= 8'h00;
            wData         <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awready && s_axi_awvalid)
            begin
                s_axi_awready <= 1'b0;
                awAddr        <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid)
            begin
                s_axi_wready <= 1'b0;
                wData <= s_axi_wdata & {{8{s_axi_wstrb[3]}},
                    {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                    {8{s_axi_wstrb[0]}}};
            end
            if (wrGo)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMap ? 2'h0 : 2'h2;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel, answer one cycle after address
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end
        else if (s_axi_arready && s_axi_arvalid)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdMux;
            s_axi_rresp   <= rdMap ? 2'h0 : 2'h2;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // sticky events, mask, level interrupt
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqStat   <= 2'h0;
            irqMask   <= 2'h0;
            alertPrev <= 1'b0;
            irq       <= 1'b0;
        end
        else
        begin
            alertPrev <= alertNow;
            irqStat   <= (irqStat & ~w1c) | setEv;
            irq       <= |(irqStat & irqMask);
            if (wrGo && aIrqM)
                irqMask <= wData[1:0];
        end
    end

    // limit order is checked by the device, not here
    // frame engine: clock divider and shifting
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state   <= FLC_H_IDLE;
            divCnt  <= 8'h00;
            linkClk <= 1'b0;
            frameN  <= 1'b1;
            cmdLine <= 1'b0;
            txShift <= '0;
            rdShift <= 16'h0000;
            bitCnt  <= 5'h00;
        end
        else if (launch)
        begin
            state   <= FLC_H_RUN;
            divCnt  <= 8'h00;
            frameN  <= 1'b0;
            txShift <= txWord;
            cmdLine <= txWord.rd;
            bitCnt  <= 5'h00;
        end
        else if (!idle)
        begin
            divCnt <= tick ? 8'h00 : divCnt + 8'h01;
            if (tick && state == FLC_H_END)
                state <= FLC_H_IDLE;
            else if (tick && !linkClk)
            begin
                linkClk <= 1'b1;
                bitCnt  <= bitCnt + 5'h01;
                if (bitCnt >= `FLC_HDR_BITS)
                    rdShift <= {rdShift[14:0], inS[1]};
            end
            else if (tick)
            begin
                linkClk <= 1'b0;
                if (bitCnt == `FLC_FRAME_BITS)
                begin
                    frameN  <= 1'b1;
                    cmdLine <= 1'b0;
                    state   <= FLC_H_END;
                end
                else
                begin
                    cmdLine <= txShift[23];
                    txShift <= {txShift[23:0], 1'b0};
                end
            end
        end
    end

    assign link.linkClk = linkClk;
    assign link.frameN  = frameN;
    assign link.cmdLine = cmdLine;
endmodule // flc_host

// [tb/flc_asserts.sv]
// link protocol assertions for the limit checker
`timescale 1ns/1ps
module flc_asserts (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic linkClk,
    input wire logic frameN,
    input wire logic cmdLine,
    input wire logic rspLine,
    input wire logic alertN
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [4:0] nRise;
    // link clock rises counted inside a frame
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n) nRise <= 5'h00;
        else nRise <= frameN ? 5'h00 : nRise + {4'h0, $rose(linkClk)};
    // high phase of the link clock
    sequence sHigh;
        linkClk [*8] ##1 !linkClk;
    endsequence
    a_idle_low: assert property (frameN |-> !linkClk)
        else $error("link clock outside frame");
    a_first_rise: assert property ($fell(frameN) |->
        !linkClk [*8] ##1 linkClk)
        else $error("first rise misplaced");
    a_clk_width: assert property (!frameN && $rose(linkClk) |-> sHigh)
        else $error("high phase wrong");
    a_frame_bits: assert property ($rose(frameN) |-> nRise == 5'h19)
        else $error("frame bit count wrong");
    a_cmd_stable: assert property (linkClk && $past(linkClk) |->
        $stable(cmdLine))
        else $error("command moved");
    a_rsp_stable: assert property (!frameN && linkClk && $past(linkClk)
        |-> $stable(rspLine))
        else $error("response moved");
    a_frame_gap: assert property ($rose(frameN) |-> frameN [*8])
        else $error("frames too close");
    a_alert_hold: assert property ($rose(alertN) |->
        frameN && $past(frameN, 2))
        else $error("alert freed early");
endmodule // flc_asserts

// [tb/fault_limit_checker_bench.sv]
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`include "flc_map.svh"
module fault_limit_checker_bench;
    logic        mclk, arst_n, awvalid, wvalid, bready, arvalid, rready, nvmWe;
    logic        awready, wready, bvalid, arready, rvalid, irq, measStrobe;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, lf, s;
    logic [1:0]  bresp, rresp, rr, outputOn, softStart;
    logic [21:0] currentMeas;
    logic [15:0] tempMeas;
    int          err_count, n_checks, nWe, nSoft, warn;
    flc_link_if link ();
    flc_host #(.LINK_HALF(8)) flc_host_i (.mclk(mclk), .arst_n(arst_n),
        .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    flc_device flc_device_i (.mclk(mclk), .arst_n(arst_n), .link(link),
        .measStrobe(measStrobe), .currentMeas(currentMeas),
        .tempMeas(tempMeas), .outputOn(outputOn), .softStart(softStart),
        .nvmWe(nvmWe), .nvmAddr(), .nvmWdata());
    flc_asserts flc_asserts_i (.mclk(mclk), .arst_n(arst_n),
        .linkClk(link.linkClk), .frameN(link.frameN),
        .cmdLine(link.cmdLine), .rspLine(link.rspLine),
        .alertN(link.alertN));
    // next random word
    function automatic logic [31:0] nx(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic ck(logic [31:0] g, logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask
    // bus write, both channels offered together
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        s = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // one link frame, then wait for idle
    task automatic lk(logic isRd, logic [7:0] c, logic [15:0] d);
        wr(`FLC_A_CMD, {7'h00, isRd, c, d});
        do rd(`FLC_A_STAT); while (s[1] !== 1'b0);
        rd(`FLC_A_RDATA);
    endtask
    task automatic ckr(logic [7:0] c, logic [31:0] e);
        lk(1'b1, c, 16'h0000);
        ck(s & 32'h0000ffff, e);
    endtask
    task automatic ms(int c, int t);
        @(posedge mclk);
        currentMeas[10:0] <= 11'(c);
        tempMeas[7:0] <= 8'(t);
        measStrobe <= 1'b1;
        @(posedge mclk);
        measStrobe <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // clock, pulse counters and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        nWe += int'(nvmWe === 1'b1);
        nSoft += int'(softStart[0] === 1'b1);
    end
    initial
    begin
        repeat (60000) @(posedge mclk);
        err_count++;
        summarize();
    end
    // main sequence
    initial
    begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, measStrobe, arst_n} = '0;
        lf = 32'hc416de16;
        currentMeas = {11'(lf % 50), 11'h000};
        tempMeas = 16'h1e1e;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        ckr(8'h4a, 32'hf836);
        ck(irq, 1'b0);
        wr(`FLC_A_IRQM, 32'h1);
        repeat (2) @(posedge mclk);
        ck(irq, 1'b1);
        wr(`FLC_A_IRQS, 32'h1);
        repeat (2) @(posedge mclk);
        ck(irq, 1'b0);
        ckr(8'h4f, 32'h0091);
        lf = nx(lf);
        warn = 4 + int'(lf % 56);
        lk(1'b0, 8'h4a, {lf[15:7], 7'(warn)});
        ckr(8'h4a, 32'hf800 | warn);
        lk(1'b0, 8'h4a, 16'h003d);
        ckr(8'h4a, 32'hf800 | warn);
        rd(`FLC_A_STAT);
        ck(s[0], 1'b1);
        ckr(8'h7e, 32'h0040);
        lk(1'b0, 8'h03, 16'h0000);
        rd(`FLC_A_STAT);
        ck(s[0], 1'b0);
        ms(warn, 100);
        ckr(8'h7b, 32'h0000);
        ms(warn + 1, 100);
        ckr(8'h7b, 32'h0020);
        ckr(8'h79, 32'h4001);
        lk(1'b0, 8'h4f, 16'h007d);
        ckr(8'h4f, 32'h0091);
        ms(0, 146);
        ck(outputOn[0], 1'b0);
        ckr(8'h7d, 32'h00c0);
        ms(0, 126);
        ck(outputOn[0], 1'b0);
        ms(0, 125);
        ck(outputOn[0], 1'b1);
        ck(nSoft, 1);
        lk(1'b0, 8'h15, 16'h0000);
        repeat (20) @(posedge mclk);
        ck(nWe, 8);
        lk(1'b0, 8'h00, 16'h0001);
        lk(1'b0, 8'h4a, 16'h0014);
        ckr(8'h4a, 32'hf814);
        lk(1'b0, 8'h00, 16'h0000);
        ckr(8'h4a, 32'hf800 | warn);
        rd(8'h14);
        ck(rr, 2'h2);
        summarize();
    end
endmodule // fault_limit_checker_bench
